/* design/tws_params.svh */
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH
// device type code, arbitrary neutral value (not a real part's code)
`define TWS_TYPE_CODE      4'h5
// position of the direction bit in the address byte
`define TWS_DIR_BIT        0
// bytes held for one page write
`define TWS_PAGE_BYTES     8
// address bits that wrap inside a page
`define TWS_PAGE_ABITS     3
// bits per byte, the acknowledge is the ninth
`define TWS_BYTE_BITS      8
// internal write cycle, microseconds, plain default
`define TWS_NVW_TIME_US    5000
// system clock rate in MHz
`define TWS_CLK_MHZ        25
// memory size in bytes
`define TWS_MEM_BYTES      256
`endif

/* design/tws_pkg.sv */
package tws_pkg;
	// serial engine states, gray coded along the usual path
	typedef enum logic [2:0] {
		TWS_IDLE  = 3'h0,
		TWS_ADDR  = 3'h1,
		TWS_AACK  = 3'h3,
		TWS_WRX   = 3'h2,
		TWS_WACK  = 3'h6,
		TWS_RTX   = 3'h7,
		TWS_RACK  = 3'h5
	} tws_state_t;
	typedef logic [7:0] tws_byte_t;
endpackage

/* design/tws_cdc_if.sv */
`timescale 1ns/1ps
`default_nettype none
// crossing signals between the link logic and the write timer
interface tws_cdc_if;
	logic	commit_tgl;	// link side toggles once per committed write
	logic	busy;	// system side level, write cycle running
	modport link (output commit_tgl, input busy);
	modport sys (input commit_tgl, output busy);
endinterface
`default_nettype wire

/* design/tws_nv_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// self-timed write cycle on the system clock
module tws_nv_timer #(
	parameter int unsigned NVW_CYCLES = 125000
) (
	input  wire logic	sys_clk,
	input  wire logic	rst,
	tws_cdc_if.sys	cdc,
	output var logic	done_tgl
);
	import tws_pkg::*;
	logic	s1_r, s2_r, s3_r;	// toggle synchroniser and history
	logic [31:0]	cnt_r;	// cycles left in the write cycle
	logic	busy_r;	// write cycle running
	logic	done_r;	// toggles when the cycle ends
	wire	start = s2_r ^ s3_r;	// one pulse per commit
	wire	last = busy_r && (cnt_r == 32'h1);
	assign cdc.busy = busy_r;
	assign done_tgl = done_r;
	// synchronise the commit toggle; only s2 reads s1
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= cdc.commit_tgl;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	// counts down the write time; a new start pulse takes priority and restarts it even while busy [R7] [R23]
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_r  <= 32'h0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else if (start) begin
			cnt_r  <= NVW_CYCLES;
			busy_r <= 1'b1;
		end else if (last) begin
			cnt_r  <= 32'h0;
			busy_r <= 1'b0;
			done_r <= ~done_r;
		end else if (busy_r) begin
			cnt_r <= cnt_r - 32'h1;
		end
	end
endmodule
`default_nettype wire

/* design/tws_slave.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tws_params.svh"
// Summary of operation
// R1: master clocks nine times, then START
// R2: address byte: type, select, direction, MSB first
// R3: direction one reads, zero writes
// R4: ack only on type and select match
// R5: memory address byte acknowledged in write
// R6: each written byte acked, STOP ends write
// R7: STOP starts timed write, inputs ignored
// R8: page write of up to eight bytes
// R9: commit only on STOP, else discard
// R10: no address ack while write runs
// R11: address register holds last plus one
// R12: read without address starts at register
// R13: random read uses dummy write, restart
// R14: acked reads continue at next address
// R15: nack ends read, slave releases line
// R16: START and STOP seen any time
// R17: one bit per clock pulse, stable high
// R18: ack held low through ninth pulse
// R19: works at standard and fast rates
// R20: master makes clock, START and STOP
// R21: master starts only on idle bus
// R22: idle after power-on, STOP, write done
// R23: write cycle time is a parameter
// R24: page write wraps inside aligned page
module tws_slave #(
	parameter int unsigned NVW_TIME_US = `TWS_NVW_TIME_US,
	parameter int unsigned NVW_CYCLES  = NVW_TIME_US * `TWS_CLK_MHZ
) (
	input  wire logic	sys_clk,	// system clock, 25 MHz
	input  wire logic	rst,	// asynchronous power-up reset
	input  wire logic	scl_clk,	// serial clock from the master
	input  wire logic	sda_in,	// data line level
	output var logic	sda_out,	// driven level, always zero
	output var logic	sda_oe,	// high while pulling the line low
	input  wire logic	select_pin_high,	// hard-wired select bits
	input  wire logic	select_pin_mid,
	input  wire logic	select_pin_low,
	output var logic	nv_busy,	// write cycle running
	output var logic	link_idle	// high while no write cycle runs
);
	import tws_pkg::*;

	localparam int unsigned PB = `TWS_PAGE_BYTES;
	localparam int unsigned AW = `TWS_PAGE_ABITS;

	tws_cdc_if cdc ();
	logic	done_tgl;	// timer end toggle, system domain

	tws_nv_timer #(
		.NVW_CYCLES (NVW_CYCLES)
	) u_timer (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.cdc      (cdc.sys),
		.done_tgl (done_tgl)
	);

	// memory array; written only when a write cycle commits
	tws_byte_t	mem_r [`TWS_MEM_BYTES];

	// link domain state
	tws_state_t	st_r, st_nxt;	// bit engine state
	logic [3:0]	bit_r;	// bit count inside the byte
	tws_byte_t	sh_r;	// receive shift register
	tws_byte_t	tx_r;	// transmit shift register
	tws_byte_t	ptr_r;	// internal address register
	logic	addr_phase_r;	// next written byte is the memory address
	logic	dir_rd_r;	// current transfer reads
	tws_byte_t	pg_data_r [PB];	// page buffer
	logic [PB-1:0]	pg_vld_r;	// filled page entries
	tws_byte_t	pg_base_r;	// address of the first page byte
	logic	pending_r;	// page holds data awaiting STOP
	logic	commit_r;	// toggle handed to the timer
	logic	ack_drive_r;	// pull the line low this bit
	logic	busy_s1_r, busy_s2_r;	// busy level into the link domain
	logic	sda_d_r;	// data level sampled on last clock rise

	// start/stop detection runs off the data line edges while clock is high [R16]
	logic	start_tgl_r, stop_tgl_r;	// toggles from the detectors
	logic	st_seen_r, sp_seen_r;	// consumed copies in link domain

	always_ff @(negedge sda_in or posedge rst) begin
		if (rst) begin
			start_tgl_r <= 1'b0;
		end else if (scl_clk) begin
			start_tgl_r <= ~start_tgl_r;	// falling data with clock high [R16]
		end
	end

	// the commit leaves here: the clock stands still after a stop, so no fall would carry it [R7] [R9]
	always_ff @(posedge sda_in or posedge rst) begin
		if (rst) begin
			stop_tgl_r <= 1'b0;
			commit_r   <= 1'b0;
		end else if (scl_clk) begin
			stop_tgl_r <= ~stop_tgl_r;	// rising data with clock high [R16]
			if (pending_r) begin
				commit_r <= ~commit_r;	// pending is steady while the clock is high [R9]
			end
		end
	end

	// each condition is applied at the next clock fall; after a STOP that fall comes only with the next START
	wire	start_ev = start_tgl_r ^ st_seen_r;
	wire	stop_ev  = stop_tgl_r ^ sp_seen_r;

	// busy crosses as a level into the link clock
	always_ff @(posedge scl_clk or posedge rst) begin
		if (rst) begin
			busy_s1_r <= 1'b0;
			busy_s2_r <= 1'b0;
		end else begin
			busy_s1_r <= cdc.busy;
			busy_s2_r <= busy_s1_r;
		end
	end

	// decode of the address byte on its eighth bit [R2] [R3] [R4]
	wire [2:0]	sel_pins = {select_pin_high, select_pin_mid, select_pin_low};
	wire [7:0]	rx_byte  = {sh_r[6:0], sda_d_r};
	wire	type_ok  = rx_byte[7:4] == `TWS_TYPE_CODE;
	wire	sel_ok   = rx_byte[3:1] == sel_pins;
	wire	addr_hit = type_ok && sel_ok && !busy_s2_r;	// [R10]
	wire	is_read  = rx_byte[`TWS_DIR_BIT];	// [R3]
	wire	byte_end = bit_r == 4'(`TWS_BYTE_BITS - 1);
	wire [AW-1:0]	pg_idx = ptr_r[AW-1:0] - pg_base_r[AW-1:0];
	wire	ptr_inc_wrap = 1'b1;	// 8-bit register wraps FFh to 00h naturally
	wire [7:0]	ptr_pg_nxt = {ptr_r[7:AW], ptr_r[AW-1:0] + AW'(1)};	// [R24]

	// sample the data line on every clock rise; bits hold while clock high [R17]
	always_ff @(posedge scl_clk or posedge rst) begin
		if (rst) begin
			sda_d_r <= 1'b1;
		end else begin
			sda_d_r <= sda_in;
		end
	end

	// next state, evaluated at the clock fall ending each bit
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			TWS_IDLE: st_nxt = TWS_IDLE;
			TWS_ADDR: begin
				if (byte_end) begin
					st_nxt = addr_hit ? TWS_AACK : TWS_IDLE;	// mismatch goes idle [R4]
				end
			end
			TWS_AACK: st_nxt = dir_rd_r ? TWS_RTX : TWS_WRX;	// [R12]
			TWS_WRX: begin
				if (byte_end) begin
					st_nxt = TWS_WACK;	// [R5] [R6]
				end
			end
			TWS_WACK: st_nxt = TWS_WRX;	// more bytes without STOP [R8]
			TWS_RTX: begin
				if (byte_end) begin
					st_nxt = TWS_RACK;
				end
			end
			TWS_RACK: st_nxt = sda_d_r ? TWS_IDLE : TWS_RTX;	// nack releases [R14] [R15]
			default: st_nxt = TWS_IDLE;
		endcase
	end

	// bit engine and data path, all on the clock fall so outputs change while low [R17]
	always_ff @(negedge scl_clk or posedge rst) begin
		if (rst) begin
			st_r         <= TWS_IDLE;	// idle after power-on [R22]
			bit_r        <= 4'h0;
			sh_r         <= 8'h00;
			tx_r         <= 8'hFF;
			ptr_r        <= 8'h00;
			addr_phase_r <= 1'b0;
			dir_rd_r     <= 1'b0;
			pg_vld_r     <= '0;
			pg_base_r    <= 8'h00;
			pending_r    <= 1'b0;
			ack_drive_r  <= 1'b0;
			st_seen_r    <= 1'b0;
			sp_seen_r    <= 1'b0;
		end else if (stop_ev) begin
			sp_seen_r   <= stop_tgl_r;
			st_seen_r   <= start_tgl_r;
			st_r        <= start_ev ? TWS_ADDR : TWS_IDLE;	// idle after any STOP, unless a START followed it [R16] [R22]
			ack_drive_r <= 1'b0;
			bit_r       <= 4'h0;
			sh_r        <= 8'h00;
			pg_vld_r    <= '0;	// stale entries must not ride along with a later page
			pending_r   <= 1'b0;	// page already handed over by the stop detector [R7] [R9]
		end else if (start_ev) begin
			st_seen_r   <= start_tgl_r;
			st_r        <= TWS_ADDR;	// first rise after START is address bit 7 [R2]
			bit_r       <= 4'h0;
			sh_r        <= 8'h00;
			ack_drive_r <= 1'b0;
			pg_vld_r    <= '0;	// restart drops unstopped data [R9]
			pending_r   <= 1'b0;
		end else begin
			st_r  <= st_nxt;
			bit_r <= byte_end ? 4'h0 : bit_r + 4'h1;
			sh_r  <= rx_byte;
			ack_drive_r <= 1'b0;
			case (st_r)
				TWS_ADDR: begin
					if (byte_end && addr_hit) begin
						ack_drive_r  <= 1'b1;	// one-clock zero [R4] [R18]
						dir_rd_r     <= is_read;
						addr_phase_r <= !is_read;
						if (is_read) begin
							tx_r <= mem_r[ptr_r];	// current address data [R12]
						end
					end
				end
				TWS_AACK: begin
					bit_r <= 4'h0;
					if (dir_rd_r) begin
						ack_drive_r <= !tx_r[7];
						tx_r        <= {tx_r[6:0], 1'b1};
					end
				end
				TWS_WRX: begin
					if (byte_end) begin
						ack_drive_r <= 1'b1;	// acknowledge each byte [R5] [R6] [R18]
						if (addr_phase_r) begin
							ptr_r        <= rx_byte;	// memory address [R5] [R13]
							pg_base_r    <= rx_byte;
							addr_phase_r <= 1'b0;
						end else begin
							pg_data_r[pg_idx] <= rx_byte;	// page buffer [R8]
							pg_vld_r[pg_idx]  <= 1'b1;
							pending_r         <= 1'b1;
							ptr_r             <= ptr_pg_nxt;	// wrap inside the page [R24]
						end
					end
				end
				TWS_RTX: begin
					if (byte_end) begin
						ptr_r <= ptr_inc_wrap ? ptr_r + 8'h01 : ptr_r;	// last plus one [R11]
					end else begin
						ack_drive_r <= !tx_r[7];
						tx_r        <= {tx_r[6:0], 1'b1};
					end
				end
				TWS_WACK: begin
					bit_r <= 4'h0;	// the acknowledge bit is not part of the next byte
				end
				TWS_RACK: begin
					bit_r <= 4'h0;
					if (!sda_d_r) begin
						tx_r        <= {mem_r[ptr_r][6:0], 1'b1};	// next byte [R14]
						ack_drive_r <= !mem_r[ptr_r][7];
					end
				end
				default: ;
			endcase
		end
	end

	// the array takes the page in the link domain after the STOP; cells outside are kept
	// one process owns the array, so every entry has a single driver [R9] [R24]
	always_ff @(negedge scl_clk) begin
		if (stop_ev && pending_r) begin
			for (int i = 0; i < PB; i++) begin
				if (pg_vld_r[i]) begin
					mem_r[{pg_base_r[7:AW], AW'(pg_base_r[AW-1:0] + AW'(i))}] <= pg_data_r[i];
				end
			end
		end
	end

	assign cdc.commit_tgl = commit_r;

	// pin outputs: open drain, line only ever pulled low [R15] [R18]
	// the drive flop itself is the pin enable, changed only at clock falls
	assign sda_oe = ack_drive_r;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sda_out   <= 1'b0;
			nv_busy   <= 1'b0;
			link_idle <= 1'b1;
		end else begin
			sda_out   <= 1'b0;
			nv_busy   <= cdc.busy;	// [R10]
			link_idle <= !cdc.busy;	// idle when internal work is done [R22]
		end
	end
endmodule
`default_nettype wire

/* verif/tws_slave_props.sv */
`timescale 1ns/1ps
`default_nettype none
// watches the slave's pins; write cycle figures follow the bound instance
module tws_slave_props #(
	parameter int unsigned NVW_CYCLES = 50
) (
	input wire logic	sys_clk,
	input wire logic	rst,
	input wire logic	scl_clk,
	input wire logic	sda_in,
	input wire logic	sda_out,
	input wire logic	sda_oe,
	input wire logic	select_pin_high,
	input wire logic	select_pin_mid,
	input wire logic	select_pin_low,
	input wire logic	nv_busy,
	input wire logic	link_idle
);
	logic [19:0]	busy_cnt_r;	// cycles the write cycle has run so far
	logic [4:0]	since_stop_r;	// cycles since the last stop, saturating
	logic	sda_d_r;	// line level one cycle ago
	logic	oe_rise_r;	// drive state seen at the last clock rise
	// a stop is the line rising with the clock high; sampling coarsely is fine as the bench holds it long
	wire	stop_seen = scl_clk && sda_in && !sda_d_r;
	wire [4:0]	since_nxt = stop_seen ? 5'h00 : (since_stop_r == 5'h1F ? 5'h1F : since_stop_r + 5'h01);
	// counters on the system clock
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			busy_cnt_r <= 20'h00000;
			since_stop_r <= 5'h1F;
			sda_d_r <= 1'b1;
		end else begin
			busy_cnt_r <= nv_busy ? busy_cnt_r + 20'h00001 : 20'h00000;
			since_stop_r <= since_nxt;
			sda_d_r <= sda_in;
		end
	end
	// drive state captured at each rise, held through the high phase
	always_ff @(posedge scl_clk or posedge rst) begin
		if (rst) oe_rise_r <= 1'b0;
		else oe_rise_r <= sda_oe;
	end
	oe_level_a: assert property (@(posedge sys_clk) disable iff (rst) sda_oe |-> !sda_out)
		else $error("data line driven high");
	idle_flag_a: assert property (@(posedge sys_clk) disable iff (rst) link_idle == !nv_busy)
		else $error("idle flag disagrees with busy");
	busy_max_a: assert property (@(posedge sys_clk) disable iff (rst) busy_cnt_r <= NVW_CYCLES + 4)
		else $error("write cycle too long");
	busy_min_a: assert property (@(posedge sys_clk) disable iff (rst) $fell(nv_busy) |-> busy_cnt_r >= NVW_CYCLES - 1)
		else $error("write cycle too short");
	oe_steady_a: assert property (@(negedge scl_clk) disable iff (rst) sda_oe == oe_rise_r)
		else $error("drive changed while clock high");
	busy_deaf_a: assert property (@(posedge scl_clk) disable iff (rst) nv_busy [*3] |-> !sda_oe)
		else $error("answered during write cycle");
	commit_stop_a: assert property (@(posedge sys_clk) disable iff (rst) $rose(nv_busy) |-> since_stop_r < 5'h10)
		else $error("write cycle without stop");
	reset_idle_a: assert property (@(posedge sys_clk) disable iff (rst) $fell(rst) |-> link_idle && !nv_busy && !sda_oe)
		else $error("not idle after reset");
	ack_seen_c: cover property (@(posedge scl_clk) disable iff (rst) sda_oe);
	busy_start_c: cover property (@(posedge sys_clk) disable iff (rst) $rose(nv_busy));
	busy_end_c: cover property (@(posedge sys_clk) disable iff (rst) $fell(nv_busy));
endmodule
bind tws_slave tws_slave_props #(.NVW_CYCLES(NVW_CYCLES)) u_props (.sys_clk(sys_clk), .rst(rst),
	.scl_clk(scl_clk), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .select_pin_high(select_pin_high),
	.select_pin_mid(select_pin_mid), .select_pin_low(select_pin_low), .nv_busy(nv_busy), .link_idle(link_idle));
`default_nettype wire

/* verif/tws_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
// bus master: 48 ns clock made only inside frames, line pulled up elsewhere
module tws_master_model (
	output var logic	scl_clk,
	output var logic	pull_low,
	input wire logic	sda
);
	// idle bus: both lines high, clock stands still
	initial begin
		scl_clk = 1'b1;
		pull_low = 1'b0;
	end
	// data moves only while the clock is low, one pulse per bit
	task automatic bit_out(input logic b);
		pull_low = !b;
		#12 scl_clk = 1'b1;
		#24 scl_clk = 1'b0;
		#12;
	endtask
	// line released so the slave or the pull-up decides it
	task automatic bit_in(output logic b);
		pull_low = 1'b0;
		#12 scl_clk = 1'b1;
		#12 b = sda;
		#12 scl_clk = 1'b0;
		#12;
	endtask
	// falling line with clock high, also serves as a repeated start
	task automatic start();
		pull_low = 1'b0;
		#12 scl_clk = 1'b1;
		#12 pull_low = 1'b1;
		#24 scl_clk = 1'b0;
		#12;
	endtask
	// rising line with clock high; the low is held long so it is seen
	task automatic stop();
		pull_low = 1'b1;
		#24 scl_clk = 1'b1;
		#24 pull_low = 1'b0;
		#24;
	endtask
	// nine released clocks bring a confused slave back
	task automatic recover();
		repeat (9) bit_out(1'b1);
	endtask
	// eight bits msb first, then the answer bit
	task automatic wr_byte(input tws_pkg::tws_byte_t d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) bit_out(d[i]);
		bit_in(b);
		ack = !b;
	endtask
	// withholding the answer marks the last byte
	task automatic rd_byte(output tws_pkg::tws_byte_t d, input logic more);
		for (int i = 7; i >= 0; i--) bit_in(d[i]);
		bit_out(!more);
	endtask
endmodule
`default_nettype wire

/* verif/tws_slave_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tws_params.svh"
module tws_slave_tb_top;
	import tws_pkg::*;
	logic	sys_clk, rst;
	logic [2:0]	sel_pins;	// select straps, high to low
	wire logic	scl_clk, m_pull, sda_out, sda_oe, nv_busy, link_idle;
	wire logic	sda_line = !(m_pull || (sda_oe && !sda_out));	// pull-up wins when nobody pulls
	int	fail_count, compares, cyc;
	tws_byte_t	mem [256];	// what the bench expects in storage
	tws_byte_t	dev, cur, a;	// address byte, modelled address register
	logic	ack;
	tws_slave #(.NVW_TIME_US(2)) DUT (.sys_clk(sys_clk), .rst(rst), .scl_clk(scl_clk), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .select_pin_high(sel_pins[2]), .select_pin_mid(sel_pins[1]),
		.select_pin_low(sel_pins[0]), .nv_busy(nv_busy), .link_idle(link_idle));
	tws_master_model u_master (.scl_clk(scl_clk), .pull_low(m_pull), .sda(sda_line));
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// the run needs well under a thousand cycles; this ceiling only catches a hang
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	function automatic logic exp_ack(input tws_byte_t b, input logic [2:0] s);
		return b[7:4] == `TWS_TYPE_CODE && b[3:1] == s;
	endfunction
	function automatic tws_byte_t page_addr(input tws_byte_t b, input int i);
		return {b[7:3], b[2:0] + 3'(i)};
	endfunction
	task automatic chk_bit(input logic got, input logic exp, input string what);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask
	task automatic chk_byte(input tws_byte_t got, input tws_byte_t exp, input string what);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	// bounded wait for the write cycle to reach the wanted level
	task automatic wait_busy(input logic lvl, input int lim);
		for (int k = 0; k < lim && nv_busy !== lvl; k++) @(posedge sys_clk);
		@(negedge sys_clk);
		chk_bit(nv_busy, lvl, "write cycle level");
	endtask
	// without a stop the bytes are only held, never stored
	task automatic write_seq(input tws_byte_t ad, input int n, input logic close);
		tws_byte_t v;
		u_master.start();
		u_master.wr_byte(dev, ack);
		chk_bit(ack, 1'b1, "write address");
		u_master.wr_byte(ad, ack);
		chk_bit(ack, 1'b1, "memory address");
		for (int i = 0; i < n; i++) begin
			v = 8'($urandom);
			if (close) mem[page_addr(ad, i)] = v;
			u_master.wr_byte(v, ack);
			chk_bit(ack, 1'b1, "data byte");
		end
		if (close) u_master.stop();
	endtask
	task automatic read_seq(input logic pick, input tws_byte_t ad, input int n);
		tws_byte_t got;
		if (pick) begin
			u_master.start();
			u_master.wr_byte(dev, ack);
			u_master.wr_byte(ad, ack);
			cur = ad;
		end
		u_master.start();
		u_master.wr_byte(dev | 8'h01, ack);
		chk_bit(ack, 1'b1, "read address");
		for (int i = 0; i < n; i++) begin
			u_master.rd_byte(got, i < n - 1);
			chk_byte(got, mem[cur], "read data");
			cur = cur + 8'h01;
		end
		chk_bit(sda_oe, 1'b0, "line released");
		u_master.stop();
	endtask
	task automatic tally_and_finish();
		if (fail_count == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		sel_pins = 3'h0;
		fail_count = 0;
		compares = 0;
		cyc = 0;
		void'($urandom(70));
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk) rst = 1'b0;
		repeat (3) @(negedge sys_clk);
		u_master.recover();
		// address decode: foreign type, wrong select, matching select
		for (int i = 0; i < 9; i++) begin
			@(negedge sys_clk) sel_pins = 3'($urandom);
			a = 8'($urandom);
			if (i % 3 != 0) a[7:4] = `TWS_TYPE_CODE;
			if (i % 3 == 2) a[3:1] = sel_pins;
			a[0] = 1'b0;
			u_master.start();
			u_master.wr_byte(a, ack);
			chk_bit(ack, exp_ack(a, sel_pins), "device address");
			u_master.stop();
			wait_busy(1'b0, 400);
		end
		dev = {4'(`TWS_TYPE_CODE), sel_pins, 1'b0};
		// ten bytes into the top page wrap inside it
		write_seq({5'h1F, 3'($urandom)}, 10, 1'b1);
		wait_busy(1'b1, 16);
		u_master.start();
		u_master.wr_byte(dev, ack);
		chk_bit(ack, 1'b0, "poll while busy");
		u_master.stop();
		wait_busy(1'b0, 400);
		chk_bit(link_idle, 1'b1, "idle after write");
		u_master.start();
		u_master.wr_byte(dev, ack);
		chk_bit(ack, 1'b1, "poll after write");
		u_master.stop();
		write_seq(8'h00, 1, 1'b1);
		wait_busy(1'b1, 16);
		wait_busy(1'b0, 400);
		// abandoned write, then a read through a repeated start
		write_seq(8'hFC, 1, 1'b0);
		read_seq(1'b1, 8'hFC, 1);
		wait_busy(1'b0, 16);
		read_seq(1'b1, 8'hFF, 2);
		read_seq(1'b1, 8'hFA, 1);
		read_seq(1'b0, 8'h00, 2);
		tally_and_finish();
	end
endmodule
`default_nettype wire
